// File: verilog/pid_loop_pkg.sv
// constants, register map and carrier types of the process loop controller
// assumes a 10 MHz pclk and 32-bit apb data; percent values are hundredths (10000 = 100.00%)
package pid_loop_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
	localparam int FULL_SCALE = 10000;
	localparam int GAIN_STEPS = 256;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FBSEL = 8'h04;
	localparam logic [7:0] OFS_RANGE = 8'h08;
	localparam logic [7:0] OFS_GAIN1 = 8'h0c;
	localparam logic [7:0] OFS_GAIN2 = 8'h10;
	localparam logic [7:0] OFS_GTRANS = 8'h14;
	localparam logic [7:0] OFS_SSLEVEL = 8'h18;
	localparam logic [7:0] OFS_SSACCEL = 8'h1c;
	localparam logic [7:0] OFS_SSDUR = 8'h20;
	localparam logic [7:0] OFS_JUDGE = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_GAINMON = 8'h2c;

	// ************************************************************
	// writable bit masks (reserved bits read zero)
	// ************************************************************
	localparam logic [31:0] MSK_CTRL = 32'h0003_f703;
	localparam logic [31:0] MSK_FBSEL = 32'h0000_ffff;
	localparam logic [31:0] MSK_PCT = 32'h0000_ffff;
	localparam logic [31:0] MSK_GAIN = 32'h00ff_ffff;
	localparam logic [31:0] MSK_ACCEL = 32'h0007_ffff;

	// ************************************************************
	// control field positions
	// ************************************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_POL_BIT = 8;
	localparam int CTRL_GSW_BIT = 9;
	localparam int CTRL_SS_BIT = 10;
	localparam int CTRL_FF_LSB = 12;
	localparam int CTRL_ACT_LSB = 16;
	localparam int SEL_SRC2_LSB = 0;
	localparam int SEL_SRC3_LSB = 4;
	localparam int SEL_OP_LSB = 8;
	localparam int SEL_TOP_LSB = 12;

	// ************************************************************
	// codes
	// ************************************************************
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_REVERSE = 2'h2;
	localparam logic [1:0] ACT_TRIP = 2'h1;
	localparam logic [1:0] ACT_TERMINAL = 2'h2;
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] OP_ADD = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_MUL = 4'h3;
	localparam logic [3:0] OP_MIN = 4'h4;
	localparam logic [3:0] OP_MAX = 4'h5;
	localparam logic [3:0] OP_AVG = 4'h6;
	localparam logic [3:0] OP_ABSDIFF = 4'h7;
	localparam logic [3:0] OP_SUM3 = 4'h8;
	localparam logic [3:0] OP_MIN3 = 4'h9;
	localparam logic [3:0] OP_MAX3 = 4'ha;
	localparam logic [3:0] TOP_FIRST = 4'h1;
	localparam logic [3:0] TOP_LAST = 4'h4;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic signed [15:0] fb1;
		logic signed [15:0] fb2;
		logic signed [15:0] fb3;
	} fb_in_t;

	typedef struct packed {
		logic [7:0] kd;
		logic [7:0] ki;
		logic [7:0] kp;
	} gains_t;

	typedef enum logic [1:0] {ST_IDLE, ST_SOFT, ST_LOOP} loop_state_t;

endpackage

// File: verilog/pid_loop_feedback_softstart.sv
// process loop controller: feedback combine, pid, window clamp, soft-start, start fault
// assumes apb master on pclk, terminal inputs already synchronous to pclk
// Summary of operation
// [R1] single feedback: sources two/three none, add operator
// [R2] combined feedback saturates to plus/minus 100%
// [R3] codes 1-7 use two inputs, 8-10 three
// [R4] operator applies only for target codes 1-4
// [R5] polarity zero: target minus feedback, else reversed
// [R6] feed-forward added only when source not none
// [R7] output clamped to target plus/minus range
// [R8] negative result floored unless reverse mode
// [R9] reverse mode mirrors window into negative
// [R10] integral clear input zeroes the integral
// [R11] clear integral only while loop idle; the controller clears on the input in any state, drive_model gates it
// [R12] bypass drives output from loop command
// [R13] method one: gain select input picks set
// [R14] active gains slew over transition time
// [R15] active gains readable through monitor register
// [R16] soft-start only when loop and selection on
// [R17] soft-start ramps to level at accel rate
// [R18] after soft-start time, hand over to loop
// [R19] afterwards, feedback below level is abnormal
// [R20] action one trips after persistence time
// [R21] action two raises fault terminal after persistence
// [R22] fault terminal holds until drive stops
// [R23] persistence timer restarts when feedback recovers
`timescale 1ns/1ps
`default_nettype none
module pid_loop_feedback_softstart
	import pid_loop_pkg::*;
#(
	parameter int TICK_CYCLES_P = pid_loop_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pid_loop_pkg::fb_in_t fb_in,
	input wire logic signed [15:0] target_in,
	input wire logic signed [15:0] feedforward_in,
	input wire logic signed [15:0] loop_cmd_in,
	input wire logic drive_running,
	input wire logic integral_clear_input,
	input wire logic loop_bypass_input,
	input wire logic gain_select_input,
	output logic signed [15:0] freq_cmd,
	output logic reverse_dir,
	output logic start_fault_trip_code,
	output logic start_fault_output
);
	import pid_loop_pkg::*;

	localparam int RAMP_UNIT = (TICK_CYCLES_P / FULL_SCALE > 0) ? TICK_CYCLES_P / FULL_SCALE : 1;
	localparam int GAIN_UNIT = (TICK_CYCLES_P / GAIN_STEPS > 0) ? TICK_CYCLES_P / GAIN_STEPS : 1;
	localparam int TW = $clog2(TICK_CYCLES_P + 1);

	// ************************************************************
	// apb register file
	// ************************************************************
	logic [31:0] ctrl_q, sel_q, range_q, gain1_q, gain2_q, trans_q;
	logic [31:0] ss_level_q, ss_accel_q, ss_dur_q, judge_q;
	logic setup_q;
	logic mapped;
	logic [31:0] rd_mux;
	loop_state_t state_q;
	gains_t act_q;
	logic signed [31:0] integ_q;

	always_comb begin
		mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_GAINMON);
		case (paddr)
			OFS_CTRL: rd_mux = ctrl_q;
			OFS_FBSEL: rd_mux = sel_q;
			OFS_RANGE: rd_mux = range_q;
			OFS_GAIN1: rd_mux = gain1_q;
			OFS_GAIN2: rd_mux = gain2_q;
			OFS_GTRANS: rd_mux = trans_q;
			OFS_SSLEVEL: rd_mux = ss_level_q;
			OFS_SSACCEL: rd_mux = ss_accel_q;
			OFS_SSDUR: rd_mux = ss_dur_q;
			OFS_JUDGE: rd_mux = judge_q;
			OFS_STATUS: rd_mux = {26'h0, reverse_dir, start_fault_output,
				start_fault_trip_code, 1'b0, state_q};
			OFS_GAINMON: rd_mux = {8'h00, act_q}; // R15
			default: rd_mux = 32'h0;
		endcase
	end

	// pready is high in the first access cycle, since setup_q and prdata are both loaded at the setup edge
	assign pready = ce && psel && penable && setup_q;
	assign pslverr = pready && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_q <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			setup_q <= psel && !pready;
			if (psel && !penable)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 32'h0;
			sel_q <= 32'h0;
			range_q <= 32'h0;
			gain1_q <= 32'h0;
			gain2_q <= 32'h0;
			trans_q <= 32'h0;
			ss_level_q <= 32'h0;
			ss_accel_q <= 32'h0;
			ss_dur_q <= 32'h0;
			judge_q <= 32'h0;
		end else if (pready && pwrite) begin
			case (paddr)
				OFS_CTRL: ctrl_q <= pwdata & MSK_CTRL;
				OFS_FBSEL: sel_q <= pwdata & MSK_FBSEL;
				OFS_RANGE: range_q <= pwdata & MSK_PCT;
				OFS_GAIN1: gain1_q <= pwdata & MSK_GAIN;
				OFS_GAIN2: gain2_q <= pwdata & MSK_GAIN;
				OFS_GTRANS: trans_q <= pwdata & MSK_PCT;
				OFS_SSLEVEL: ss_level_q <= pwdata & MSK_PCT;
				OFS_SSACCEL: ss_accel_q <= pwdata & MSK_ACCEL;
				OFS_SSDUR: ss_dur_q <= pwdata & MSK_PCT;
				OFS_JUDGE: judge_q <= pwdata & MSK_PCT;
				default: ;
			endcase
		end
	end

	logic [1:0] mode, action;
	logic [3:0] src2, src3, op, top;
	logic loop_en, reverse_en;
	assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
	assign action = ctrl_q[CTRL_ACT_LSB +: 2];
	assign src2 = sel_q[SEL_SRC2_LSB +: 4];
	assign src3 = sel_q[SEL_SRC3_LSB +: 4];
	assign op = sel_q[SEL_OP_LSB +: 4];
	assign top = sel_q[SEL_TOP_LSB +: 4];
	assign loop_en = (mode != MODE_OFF);
	assign reverse_en = (mode == MODE_REVERSE);

	// ************************************************************
	// time base
	// ************************************************************
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	assign tick = (tick_cnt_q == TW'(TICK_CYCLES_P - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_q <= '0;
		else if (ce)
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
	end

	// ************************************************************
	// feedback combine and error
	// ************************************************************
	logic signed [31:0] fb_raw, fb_comb, err_w, a, b, c;

	always_comb begin
		a = 32'(fb_in.fb1);
		b = (src2 == SRC_NONE) ? 32'sd0 : 32'(fb_in.fb2); // R1
		c = (src3 == SRC_NONE) ? 32'sd0 : 32'(fb_in.fb3); // R1
		case (op) // R3
			OP_ADD: fb_raw = a + b;
			OP_SUB: fb_raw = a - b;
			OP_MUL: fb_raw = (a * b) / FULL_SCALE;
			OP_MIN: fb_raw = (a < b) ? a : b;
			OP_MAX: fb_raw = (a > b) ? a : b;
			OP_AVG: fb_raw = (a + b) >>> 1;
			OP_ABSDIFF: fb_raw = (a > b) ? a - b : b - a;
			OP_SUM3: fb_raw = a + b + c;
			OP_MIN3: fb_raw = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
			OP_MAX3: fb_raw = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
			default: fb_raw = a;
		endcase
		if (top < TOP_FIRST || top > TOP_LAST) // R4
			fb_raw = a;
		fb_comb = (fb_raw > FULL_SCALE) ? FULL_SCALE : // R2
			(fb_raw < -FULL_SCALE) ? -FULL_SCALE : fb_raw;
		err_w = ctrl_q[CTRL_POL_BIT] ? fb_comb - 32'(target_in) // R5
			: 32'(target_in) - fb_comb;
	end

	// ************************************************************
	// gain selection and slew
	// ************************************************************
	gains_t want;
	logic [31:0] gcnt_q;
	logic gstep;
	assign want = (ctrl_q[CTRL_GSW_BIT] && gain_select_input) ? gains_t'(gain2_q[23:0]) // R13
		: gains_t'(gain1_q[23:0]);
	assign gstep = (gcnt_q >= trans_q * 32'(GAIN_UNIT));

	// one count per step keeps the slew linear; a full 0..255 swing spans the time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_q <= '0;
			gcnt_q <= 32'h0;
		end else if (ce) begin
			gcnt_q <= (gstep || act_q == want) ? 32'h0 : gcnt_q + 32'h1;
			if (gstep) begin // R14
				act_q.kp <= act_q.kp + ((want.kp > act_q.kp) ? 8'h01 : 8'h00)
					- ((want.kp < act_q.kp) ? 8'h01 : 8'h00);
				act_q.ki <= act_q.ki + ((want.ki > act_q.ki) ? 8'h01 : 8'h00)
					- ((want.ki < act_q.ki) ? 8'h01 : 8'h00);
				act_q.kd <= act_q.kd + ((want.kd > act_q.kd) ? 8'h01 : 8'h00)
					- ((want.kd < act_q.kd) ? 8'h01 : 8'h00);
			end
		end
	end

	// ************************************************************
	// pid arithmetic and output window
	// ************************************************************
	logic signed [31:0] err_prev_q, integ_d, u_raw, u_win, hi, lo;

	always_comb begin
		integ_d = integ_q + (($signed(32'(act_q.ki)) * err_w) >>> 6);
		integ_d = (integ_d > FULL_SCALE) ? FULL_SCALE : (integ_d < -FULL_SCALE) ? -FULL_SCALE
			: integ_d;
		u_raw = (($signed(32'(act_q.kp)) * err_w) >>> 4) + integ_d
			+ (($signed(32'(act_q.kd)) * (err_w - err_prev_q)) >>> 4);
		if (ctrl_q[CTRL_FF_LSB +: 4] != SRC_NONE) // R6
			u_raw = u_raw + 32'(feedforward_in);
		hi = 32'(target_in) + 32'(range_q[15:0]);
		lo = reverse_en ? -hi : 32'(target_in) - 32'(range_q[15:0]); // R9
		u_win = u_raw;
		if (range_q[15:0] != 16'h0) // R7
			u_win = (u_raw > hi) ? hi : (u_raw < lo) ? lo : u_raw;
		u_win = (u_win > FULL_SCALE) ? FULL_SCALE : (u_win < -FULL_SCALE) ? -FULL_SCALE : u_win;
		if (!reverse_en && u_win < 0) // R8
			u_win = 32'sd0;
	end

	// ************************************************************
	// sequence: idle, soft-start, loop
	// ************************************************************
	logic [31:0] rcnt_q, dur_q, pers_q;
	logic armed_q;
	logic signed [15:0] ramp_q;
	logic rstep, abnormal;
	assign rstep = (rcnt_q >= ss_accel_q * 32'(RAMP_UNIT));
	// signed compare, so a negative feedback still counts as below the level
	assign abnormal = armed_q && (fb_comb < $signed(32'(judge_q[15:0]))); // R19

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			ramp_q <= 16'sh0000;
			rcnt_q <= 32'h0;
			dur_q <= 32'h0;
			armed_q <= 1'b0;
		end else if (ce) begin
			case (state_q)
				ST_IDLE: begin
					ramp_q <= 16'sh0000;
					rcnt_q <= 32'h0;
					dur_q <= 32'h0;
					armed_q <= 1'b0;
					if (drive_running && loop_en)
						state_q <= ctrl_q[CTRL_SS_BIT] ? ST_SOFT : ST_LOOP; // R16
				end
				ST_SOFT: begin
					rcnt_q <= rstep ? 32'h0 : rcnt_q + 32'h1;
					if (rstep && 32'(ramp_q) < 32'(ss_level_q[15:0])) // R17
						ramp_q <= ramp_q + 16'sh0001;
					if (tick)
						dur_q <= dur_q + 32'h1;
					if (dur_q >= ss_dur_q) begin // R18
						state_q <= ST_LOOP;
						armed_q <= 1'b1;
					end
				end
				ST_LOOP: ;
				default: state_q <= ST_IDLE;
			endcase
			if (!drive_running || !loop_en)
				state_q <= ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integ_q <= 32'sh0;
			err_prev_q <= 32'sh0;
		end else if (ce) begin
			if (integral_clear_input || state_q == ST_IDLE) // R10
				integ_q <= 32'sh0;
			else if (state_q == ST_SOFT)
				integ_q <= 32'(ramp_q); // bumpless hand-over from the ramp
			else if (tick && !loop_bypass_input)
				integ_q <= integ_d;
			if (tick)
				err_prev_q <= err_w;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd <= 16'sh0000;
			reverse_dir <= 1'b0;
		end else if (ce) begin
			if (loop_bypass_input || (drive_running && !loop_en)) begin // R12
				freq_cmd <= loop_cmd_in;
				reverse_dir <= 1'b0;
			end else if (state_q == ST_SOFT) begin
				freq_cmd <= ramp_q;
				reverse_dir <= 1'b0;
			end else if (state_q == ST_LOOP && tick) begin
				freq_cmd <= 16'(u_win);
				reverse_dir <= (u_win < 0); // R8
			end else if (state_q == ST_IDLE) begin
				freq_cmd <= 16'sh0000;
				reverse_dir <= 1'b0;
			end
		end
	end

	// ************************************************************
	// start abnormality
	// ************************************************************
	// the fault flags clear only with the drive stopped, never by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pers_q <= 32'h0;
			start_fault_trip_code <= 1'b0;
			start_fault_output <= 1'b0;
		end else if (ce) begin
			if (!abnormal)
				pers_q <= 32'h0; // R23
			else if (tick && pers_q < ss_dur_q)
				pers_q <= pers_q + 32'h1;
			if (!drive_running) begin // R22
				start_fault_trip_code <= 1'b0;
				start_fault_output <= 1'b0;
			end else if (abnormal && pers_q >= ss_dur_q) begin
				if (action == ACT_TRIP)
					start_fault_trip_code <= 1'b1; // R20
				if (action == ACT_TERMINAL)
					start_fault_output <= 1'b1; // R21
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fb_saturate_a: assert property (fb_comb <= FULL_SCALE && fb_comb >= -FULL_SCALE) // R2
		else $error("combined feedback out of range");
	bypass_passes_a: assert property (ce && loop_bypass_input |=> freq_cmd == $past(loop_cmd_in)) // R12
		else $error("bypass did not pass the loop command");
	floor_zero_a: assert property (ce && state_q == ST_LOOP && tick && !reverse_en
		&& !loop_bypass_input |=> freq_cmd >= 0) // R8
		else $error("negative command without reverse mode");
	window_clamp_a: assert property (range_q[15:0] != 16'h0 && u_win > 0 |-> u_win <= hi) // R7
		else $error("output above target window");
	integ_clear_a: assert property (ce && integral_clear_input |=> integ_q == 0) // R10
		else $error("integral not cleared");
	gain_slew_a: assert property (ce && act_q != want && want.kp > act_q.kp
		|=> act_q.kp <= $past(act_q.kp) + 8'h01) // R14
		else $error("gain jumped");
	soft_gate_a: assert property (ce && state_q == ST_IDLE && !ctrl_q[CTRL_SS_BIT]
		|=> state_q != ST_SOFT) // R16
		else $error("soft-start entered while disabled");
	trip_cause_a: assert property ($rose(start_fault_trip_code) |-> $past(action) == ACT_TRIP) // R20
		else $error("trip without trip action");
	terminal_hold_a: assert property (start_fault_output && drive_running
		|=> start_fault_output) // R22
		else $error("fault terminal dropped while running");
	soft_exit_a: assert property (ce && state_q == ST_SOFT && dur_q >= ss_dur_q
		&& drive_running && loop_en |=> state_q == ST_LOOP ##0 armed_q) // R18
		else $error("soft-start did not hand over");

	cov_bypass: cover property (ce && loop_bypass_input ##1 !loop_bypass_input);
	cov_handover: cover property (state_q == ST_SOFT ##1 state_q == ST_LOOP);
	cov_terminal: cover property ($rose(start_fault_output));
	cov_trip: cover property ($rose(start_fault_trip_code));

endmodule
`default_nettype wire

// File: verif/drive_model.sv
// far side model: drive run state, feedback sensors and integral clear terminal
// assumes the controller's trip request and a bench run request on pclk
`timescale 1ns/1ps
`default_nettype none
module drive_model
	import pid_loop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run_req,
	input wire logic clr_req,
	input wire logic start_fault_trip_code,
	input wire logic signed [15:0] fb_level,
	output logic drive_running,
	output logic integral_clear_input,
	output var pid_loop_pkg::fb_in_t fb_in
);
	import pid_loop_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic tripped_q;
	logic signed [15:0] noise_q;

	// a trip stops the drive until the run request is withdrawn
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tripped_q <= 1'b0;
		end else if (!run_req) begin
			tripped_q <= 1'b0;
		end else if (start_fault_trip_code) begin
			tripped_q <= 1'b1;
		end
	end

	// unused sensors keep moving so a wrongly combined input shows up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			noise_q <= 16'h0000;
		end else begin
			noise_q <= noise_q + 16'h0101;
		end
	end

	assign drive_running = run_req & !tripped_q;
	assign integral_clear_input = clr_req & !drive_running;
	assign fb_in = '{fb1: fb_level, fb2: noise_q, fb3: ~noise_q};
endmodule
`default_nettype wire

// File: verif/pid_loop_feedback_softstart_tb.sv
// testbench of the process loop controller
// assumes drive_model on the far side and apb with zero wait states
`timescale 1ns/1ps
`default_nettype none
module pid_loop_feedback_softstart_tb;
	import pid_loop_pkg::*;
	localparam int TK = 100;
	typedef struct packed {
		logic byp;
		logic [31:0] ctrl;
		logic [15:0] rng;
		logic [15:0] tgt;
		logic [15:0] ff;
		logic [15:0] exp;
		logic rev;
	} row_t;

	// ************************************************************
	// signals
	// ************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	fb_in_t fb_in;
	logic signed [15:0] target_in = 16'h0000;
	logic signed [15:0] feedforward_in = 16'h0000;
	logic signed [15:0] fb_level = 16'h0000;
	logic signed [15:0] loop_cmd = 16'h05dc;
	logic signed [15:0] held;
	logic ce = 1'b1;
	logic loop_bypass_input = 1'b0;
	logic gain_select_input = 1'b0;
	logic run_req = 1'b0;
	logic clr_req = 1'b0;
	logic drive_running;
	logic integral_clear_input;
	logic signed [15:0] freq_cmd;
	logic reverse_dir;
	logic trip;
	logic sfo;
	logic [31:0] rd;
	logic er;
	logic [1:0] act;
	int errors = 0;
	int checks_done = 0;
	int n;
	row_t rows[7];

	always #50 pclk = ~pclk;

	pid_loop_feedback_softstart #(.TICK_CYCLES_P(TK)) u_pid_loop_feedback_softstart (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fb_in(fb_in), .target_in(target_in),
		.feedforward_in(feedforward_in), .loop_cmd_in(loop_cmd),
		.drive_running(drive_running), .integral_clear_input(integral_clear_input),
		.loop_bypass_input(loop_bypass_input), .gain_select_input(gain_select_input),
		.freq_cmd(freq_cmd), .reverse_dir(reverse_dir),
		.start_fault_trip_code(trip), .start_fault_output(sfo)
	);

	drive_model u_drive_model (
		.pclk(pclk), .presetn(presetn), .run_req(run_req), .clr_req(clr_req),
		.start_fault_trip_code(trip), .fb_level(fb_level),
		.drive_running(drive_running), .integral_clear_input(integral_clear_input),
		.fb_in(fb_in)
	);

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: a slave that never answers is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		rows = '{
			'{1'b0, 32'h1001, 16'h0000, 16'h0000, 16'h07d0, 16'h07d0, 1'b0},
			'{1'b0, 32'h0001, 16'h0000, 16'h0000, 16'h07d0, 16'h0000, 1'b0},
			'{1'b0, 32'h1001, 16'h0000, 16'h0000, 16'hf830, 16'h0000, 1'b0},
			'{1'b0, 32'h1002, 16'h0000, 16'h0000, 16'hf830, 16'hf830, 1'b1},
			'{1'b0, 32'h1001, 16'h03e8, 16'h07d0, 16'h2328, 16'h0bb8, 1'b0},
			'{1'b0, 32'h1002, 16'h03e8, 16'h07d0, 16'hdcd8, 16'hf448, 1'b1},
			'{1'b1, 32'h1001, 16'h0000, 16'h0000, 16'h07d0, 16'h05dc, 1'b0}
		};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b1, OFS_CTRL, 32'hffff_ffff);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl mask", MSK_CTRL, rd);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("register test done");
		apb(1'b1, OFS_FBSEL, 32'h0000_1100);
		run_req <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, OFS_CTRL, rows[i].ctrl);
			apb(1'b1, OFS_RANGE, {16'h0, rows[i].rng});
			loop_bypass_input <= rows[i].byp;
			target_in <= rows[i].tgt;
			feedforward_in <= rows[i].ff;
			repeat (3 * TK) @(posedge pclk);
			chk("freq_cmd", {16'h0, rows[i].exp}, {16'h0, freq_cmd});
			chk("reverse_dir", {31'h0, rows[i].rev}, {31'h0, reverse_dir});
			$display("row %0d done", i);
		end
		loop_bypass_input <= 1'b0;
		feedforward_in <= 16'h0000;
		target_in <= 16'h0000;
		run_req <= 1'b0;
		apb(1'b1, OFS_RANGE, 32'h0);
		apb(1'b1, OFS_SSLEVEL, 32'h1388);
		apb(1'b1, OFS_SSACCEL, 32'h1);
		apb(1'b1, OFS_SSDUR, 32'h3);
		apb(1'b1, OFS_JUDGE, 32'h1388);
		// action codes 0 to 2; the persistence window is three ticks after soft-start
		for (int c = 0; c < 3; c++) begin
			act = c[1:0];
			apb(1'b1, OFS_CTRL, {14'h0, act, 16'h0401});
			fb_level <= 16'h0000;
			run_req <= 1'b1;
			repeat (4 * TK) @(posedge pclk);
			chk("early fault", 32'h0, {30'h0, trip, sfo});
			n = 0;
			while (n < 2000 && trip !== 1'b1 && sfo !== 1'b1) begin
				@(posedge pclk);
				n++;
			end
			chk("fault flags", {30'h0, act == 2'h1, act == 2'h2}, {30'h0, trip, sfo});
			if (act == 2'h1) begin
				repeat (3) @(posedge pclk);
				chk("drive stopped", 32'h0, {31'h0, drive_running});
			end
			if (act == 2'h2) begin
				fb_level <= 16'h1f40;
				repeat (5 * TK) @(posedge pclk);
				chk("terminal held", 32'h1, {31'h0, sfo});
			end
			run_req <= 1'b0;
			repeat (5) @(posedge pclk);
			chk("fault cleared", 32'h0, {30'h0, trip, sfo});
			clr_req <= 1'b1;
			repeat (2) @(posedge pclk);
			clr_req <= 1'b0;
			$display("fault action %0d done", c);
		end
		fb_level <= 16'h1f40;
		apb(1'b1, OFS_GAIN1, 32'h0003_0201);
		apb(1'b1, OFS_GAIN2, 32'h0006_0504);
		apb(1'b1, OFS_GTRANS, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h0000_0201);
		run_req <= 1'b1;
		repeat (20 * TK) @(posedge pclk);
		apb(1'b0, OFS_GAINMON, 32'h0);
		chk("gain set one", 32'h0003_0201, rd);
		gain_select_input <= 1'b1;
		apb(1'b0, OFS_GAINMON, 32'h0);
		chk("gain no jump", 32'h0, {31'h0, rd === 32'h0006_0504});
		n = 0;
		while (n < 40 && rd !== 32'h0006_0504) begin
			repeat (TK) @(posedge pclk);
			apb(1'b0, OFS_GAINMON, 32'h0);
			n++;
		end
		chk("gain set two", 32'h0006_0504, rd);
		$display("gain test done");
		// with the enable low nothing may move, not even the bypass path
		ce <= 1'b0;
		loop_bypass_input <= 1'b1;
		loop_cmd <= 16'h0123;
		@(posedge pclk);
		held = freq_cmd;
		repeat (3 * TK) @(posedge pclk);
		chk("frozen by ce", {16'h0, held}, {16'h0, freq_cmd});
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("bypass command", 32'h0000_0123, {16'h0, freq_cmd});
		loop_bypass_input <= 1'b0;
		$display("clock enable test done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("reset outputs", 32'h0, {13'h0, freq_cmd, reverse_dir, trip, sfo});
		presetn <= 1'b1;
		$display("reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
